// ===== hdl/asq_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// - disabled sequencer ignores triggers; a sequence already running still completes and captures
// - enabled sequencer runs steps on each trigger
// - dma enabled: request follows fifo fill level
// - dma disabled: never any dma request
// - trigger with unread samples sets overflow
// - overflow sticky until cleared, otherwise harmless
// - read from empty fifo sets underflow
// - underflow sticky until cleared, otherwise harmless
// - each sample visible as its step completes
// - steps 0-7, 0-3, 0-3, 0 per sequencer
// - steps run ascending with their stored configuration
// - differential bit makes channel a pair number
// - channel field of 24 inputs, temperature select
// - last-step flag ends sequence until next trigger
// - step irq enable pulses sequencer interrupt on completion
// - comparator-routed sample bypasses the fifo
// - simultaneous triggers served by priority, zero highest
// - fifo depths eight, four, four, one
module asq_top (
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // axi4-lite write channels
  input  wire logic [11:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // axi4-lite read channels
  input  wire logic [11:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // external trigger pins, asynchronous
  input  wire logic [3:0]          trig_in,
  // converter handshake, same clock
  output logic                     conv_start,
  output logic [4:0]               conv_channel,
  output logic                     conv_diff,
  output logic                     conv_temp,
  input  wire logic                conv_done,
  input  wire asq_pkg::asq_sample_t conv_data,
  // digital comparator delivery
  output logic                     cmp_valid,
  output logic [2:0]               cmp_sel,
  output asq_pkg::asq_sample_t     cmp_data,
  // per-sequencer step interrupt pulses and dma requests
  output logic [3:0]               seq_irq,
  output logic [3:0]               dma_req
);
  import asq_pkg::*;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // fifo depth, also the number of steps
  function automatic logic [3:0] seq_depth(input logic [1:0] q);
    case (q)
      2'h0:    seq_depth = 4'h8;
      2'h1:    seq_depth = 4'h4;
      2'h2:    seq_depth = 4'h4;
      default: seq_depth = 4'h1;
    endcase
  endfunction : seq_depth

  // next pointer within a sequencer's depth
  function automatic logic [2:0] ptr_inc(input logic [2:0] p, input logic [1:0] q);
    ptr_inc = ({1'b0, p} == seq_depth(q) - 4'h1) ? 3'h0 : p + 3'h1;
  endfunction : ptr_inc

  // register readback without side effects; bit 32 flags a mapped address
  function automatic logic [32:0] rd_word(input asq_state_s c, input logic [7:0] a);
    rd_word = 33'h0;
    if (a[`ASQ_STEP_PAGE_BIT]) begin
      if ({1'b0, a[4:2]} < seq_depth(a[6:5])) begin
        rd_word = {1'b1, 19'h0, c.step_cfg[a[6:5]][a[4:2]]};
      end
    end else if (a[7:4] == `ASQ_DATA_PAGE) begin
      rd_word = {1'b1, 32'h0};
    end else begin
      case (a)
        `ASQ_OFF_CTRL:  rd_word = {1'b1, 24'h0, c.dma_en, c.seq_en};
        `ASQ_OFF_TRIG:  rd_word = {1'b1, 32'h0};
        `ASQ_OFF_FLAGS: rd_word = {1'b1, 24'h0, c.unf, c.ovf};
        `ASQ_OFF_PRIO:  rd_word = {1'b1, 24'h0, c.prio};
        `ASQ_OFF_LEVEL: rd_word = {1'b1, 16'h0, c.cnt};
        default:        rd_word = 33'h0;
      endcase
    end
  endfunction : rd_word

  // pending sequencer with the smallest priority number
  function automatic logic [2:0] pick(input logic [3:0] p, input logic [3:0][1:0] pr);
    logic [1:0] best;
    pick = 3'h0;
    best = 2'h3;
    for (int i = 0; i < 4; i++) begin
      if (p[i] && (!pick[2] || pr[i] < best)) begin
        pick = {1'b1, i[1:0]};
        best = pr[i];
      end
    end
  endfunction : pick

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  asq_state_s s;      // registered state
  asq_state_s next_s; // next state

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    logic [32:0]     rw;
    logic [31:0]     mask;
    logic [31:0]     wv;
    logic [3:0]      trig;
    logic [3:0]      ovf_set;
    logic [3:0]      unf_set;
    logic [3:0]      clr_ovf;
    logic [3:0]      clr_unf;
    logic [3:0]      push;
    logic [3:0]      pop;
    logic [2:0]      sel;
    asq_step_t       cfg;
    rw      = 33'h0;
    mask    = 32'h0;
    wv      = 32'h0;
    trig    = 4'h0;
    ovf_set = 4'h0;
    unf_set = 4'h0;
    clr_ovf = 4'h0;
    clr_unf = 4'h0;
    push    = 4'h0;
    pop     = 4'h0;
    sel     = 3'h0;
    cfg     = s.step_cfg[s.cur][s.step];
    next_s  = s;
    // one-cycle outputs fall back to idle
    next_s.conv_start = 1'b0;
    next_s.seq_irq    = 4'h0;
    next_s.cmp_valid  = 1'b0;
    // pin triggers: two flops, then edge detect on the second
    next_s.trig_s1 = trig_in;
    next_s.trig_s2 = s.trig_s1;
    next_s.trig_s3 = s.trig_s2;
    trig = s.trig_s2 & ~s.trig_s3;

    // read channel: data page pops the fifo
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s.rvalid) begin
      rw = rd_word(s, s_axi_araddr[7:0]);
      next_s.rvalid = 1'b1;
      next_s.rdata  = rw[31:0];
      next_s.rresp  = (rw[32] && s_axi_araddr[11:8] == 4'h0) ? `ASQ_RESP_OKAY : `ASQ_RESP_SLVERR;
      if (s_axi_araddr[11:4] == {4'h0, `ASQ_DATA_PAGE}) begin
        if (s.cnt[s_axi_araddr[3:2]] == 4'h0) begin
          unf_set[s_axi_araddr[3:2]] = 1'b1;
          next_s.rdata = 32'h0;
        end else begin
          pop[s_axi_araddr[3:2]] = 1'b1;
          next_s.rdata = {20'h0, s.mem[s_axi_araddr[3:2]][s.rp[s_axi_araddr[3:2]]]};
        end
      end
    end

    // write channels: address and data taken in either order
    if (s_axi_awvalid && !s.aw_got) begin
      next_s.aw_got  = 1'b1;
      next_s.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !s.w_got) begin
      next_s.w_got  = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      rw   = rd_word(s, s.aw_addr);
      mask = {{8{s.w_strb[3]}}, {8{s.w_strb[2]}}, {8{s.w_strb[1]}}, {8{s.w_strb[0]}}};
      wv   = (rw[31:0] & ~mask) | (s.w_data & mask);
      next_s.bresp = rw[32] ? `ASQ_RESP_OKAY : `ASQ_RESP_SLVERR;
      if (s.aw_addr[`ASQ_STEP_PAGE_BIT]) begin
        if (rw[32]) begin
          next_s.step_cfg[s.aw_addr[6:5]][s.aw_addr[4:2]] = wv[`ASQ_STEP_W-1:0];
        end
      end else begin
        case (s.aw_addr)
          `ASQ_OFF_CTRL: begin
            next_s.seq_en = wv[3:0];
            next_s.dma_en = wv[7:4];
          end
          `ASQ_OFF_TRIG:  trig = trig | (s.w_data[3:0] & mask[3:0]);
          `ASQ_OFF_FLAGS: begin
            clr_ovf = s.w_data[3:0] & mask[3:0];
            clr_unf = s.w_data[7:4] & mask[7:4];
          end
          `ASQ_OFF_PRIO:  next_s.prio = wv[7:0];
          default: begin
          end
        endcase
      end
    end

    // triggers: disabled sequencers ignore them
    for (int i = 0; i < 4; i++) begin
      if (trig[i] && s.seq_en[i]) begin
        next_s.pend[i] = 1'b1;
        if (s.cnt[i] != 4'h0) begin
          ovf_set[i] = 1'b1;
        end
      end
    end

    // sequencer walk through the steps
    case (s.st)
      ASQ_IDLE: begin
        sel = pick(s.pend & s.seq_en, s.prio);
        if (sel[2]) begin
          next_s.cur  = sel[1:0];
          next_s.step = 3'h0;
          next_s.pend[sel[1:0]] = 1'b0;
          next_s.st   = ASQ_START;
        end
      end
      ASQ_START: begin
        // channel, diff and temp are taken when the step starts; irq, last and comparator fields when it completes, so it must be stable
        next_s.conv_start   = 1'b1;
        next_s.conv_channel = cfg[`ASQ_F_CH_MSB:`ASQ_F_CH_LSB];
        next_s.conv_diff    = cfg[`ASQ_F_DIFF];
        next_s.conv_temp    = cfg[`ASQ_F_TEMP];
        next_s.st           = ASQ_WAIT;
      end
      ASQ_WAIT: begin
        if (conv_done) begin
          if (cfg[`ASQ_F_CMP_EN]) begin
            next_s.cmp_valid = 1'b1;
            next_s.cmp_sel   = cfg[`ASQ_F_CMP_MSB:`ASQ_F_CMP_LSB];
            next_s.cmp_data  = conv_data;
          end else if (s.cnt[s.cur] != seq_depth(s.cur)) begin
            push[s.cur] = 1'b1;
          end else begin
            ovf_set[s.cur] = 1'b1; // full fifo drops the sample
          end
          next_s.seq_irq[s.cur] = cfg[`ASQ_F_IRQ];
          if (cfg[`ASQ_F_LAST] || {1'b0, s.step} == seq_depth(s.cur) - 4'h1) begin
            next_s.st = ASQ_IDLE;
          end else begin
            next_s.step = s.step + 3'h1;
            next_s.st   = ASQ_START;
          end
        end
      end
      default: next_s.st = ASQ_IDLE;
    endcase

    // fifo pointers and levels
    for (int i = 0; i < 4; i++) begin
      if (push[i]) begin
        next_s.mem[i][s.wp[i]] = conv_data;
        next_s.wp[i] = ptr_inc(s.wp[i], i[1:0]);
      end
      if (pop[i]) begin
        next_s.rp[i] = ptr_inc(s.rp[i], i[1:0]);
      end
      next_s.cnt[i] = s.cnt[i] + {3'h0, push[i]} - {3'h0, pop[i]};
    end

    // sticky flags: a set in the clearing cycle wins
    next_s.ovf = (s.ovf & ~clr_ovf) | ovf_set;
    next_s.unf = (s.unf & ~clr_unf) | unf_set;
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s      <= '0;
      s.st   <= ASQ_IDLE;
      s.prio <= `ASQ_RST_PRIO;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign s_axi_awready = !s.aw_got;
  assign s_axi_wready  = !s.w_got;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign conv_start    = s.conv_start;
  assign conv_channel  = s.conv_channel;
  assign conv_diff     = s.conv_diff;
  assign conv_temp     = s.conv_temp;
  assign cmp_valid     = s.cmp_valid;
  assign cmp_sel       = s.cmp_sel;
  assign cmp_data      = s.cmp_data;
  assign seq_irq       = s.seq_irq;

  // dma request is a level while samples wait and dma is enabled
  generate
    for (genvar g = 0; g < 4; g++) begin : g_dma
      assign dma_req[g] = s.dma_en[g] && (s.cnt[g] != 4'h0);
    end
  endgenerate
endmodule : asq_top

// ===== hdl/asq_map.svh
`ifndef ASQ_MAP_SVH
`define ASQ_MAP_SVH
// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define ASQ_OFF_CTRL      8'h00
`define ASQ_OFF_TRIG      8'h04
`define ASQ_OFF_FLAGS     8'h08
`define ASQ_OFF_PRIO      8'h0C
`define ASQ_OFF_LEVEL     8'h10
`define ASQ_DATA_PAGE     4'h2
`define ASQ_STEP_PAGE_BIT 7
// ------------------------------------------------------------
// step word field positions
// ------------------------------------------------------------
`define ASQ_F_CH_LSB      0
`define ASQ_F_CH_MSB      4
`define ASQ_F_DIFF        5
`define ASQ_F_TEMP        6
`define ASQ_F_IRQ         7
`define ASQ_F_LAST        8
`define ASQ_F_CMP_EN      9
`define ASQ_F_CMP_LSB     10
`define ASQ_F_CMP_MSB     12
// ------------------------------------------------------------
// reset values and sizes
// ------------------------------------------------------------
`define ASQ_RST_PRIO      8'hE4
`define ASQ_SAMPLE_W      12
`define ASQ_STEP_W        13
`define ASQ_RESP_OKAY     2'h0
`define ASQ_RESP_SLVERR   2'h2
`endif

// ===== hdl/asq_pkg.sv
`include "asq_map.svh"
package asq_pkg;
  // sequencer state, one-hot
  typedef enum logic [2:0] {
    ASQ_IDLE  = 3'h1,
    ASQ_START = 3'h2,
    ASQ_WAIT  = 3'h4
  } asq_state_e;

  typedef logic [`ASQ_SAMPLE_W-1:0] asq_sample_t;
  typedef logic [`ASQ_STEP_W-1:0]   asq_step_t;

  // whole state of the sequencer block
  typedef struct packed {
    logic [3:0]            seq_en;
    logic [3:0]            dma_en;
    logic [3:0]            ovf;
    logic [3:0]            unf;
    logic [3:0]            pend;
    logic [3:0]            trig_s1;
    logic [3:0]            trig_s2;
    logic [3:0]            trig_s3;
    logic [3:0][1:0]       prio;
    logic [3:0][7:0][`ASQ_STEP_W-1:0]   step_cfg;
    logic [3:0][7:0][`ASQ_SAMPLE_W-1:0] mem;
    logic [3:0][2:0]       wp;
    logic [3:0][2:0]       rp;
    logic [3:0][3:0]       cnt;
    asq_state_e            st;
    logic [1:0]            cur;
    logic [2:0]            step;
    logic                  aw_got;
    logic                  w_got;
    logic [7:0]            aw_addr;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic                  conv_start;
    logic [4:0]            conv_channel;
    logic                  conv_diff;
    logic                  conv_temp;
    logic [3:0]            seq_irq;
    logic                  cmp_valid;
    logic [2:0]            cmp_sel;
    logic [`ASQ_SAMPLE_W-1:0] cmp_data;
  } asq_state_s;
endpackage : asq_pkg

// ===== sim/asq_conv_model.sv
`timescale 1ns/100ps
// converter stand-in: answers each start after a short or long delay
module asq_conv_model (
  // clock and reset
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // step request
  input  wire logic            conv_start,
  input  wire logic [4:0]      conv_channel,
  input  wire logic            conv_diff,
  input  wire logic            conv_temp,
  input  wire logic            slow,
  // result
  output logic                 conv_done,
  output asq_pkg::asq_sample_t conv_data
);
  import asq_pkg::*;
  int          cnt;
  asq_sample_t res;
  // result encodes the source, so the order of steps shows in the samples
  always_ff @(posedge aclk) begin
    conv_done <= 1'b0;
    conv_data <= ~conv_data; // no stale value outside the pulse
    if (!aresetn) begin
      cnt       <= 0;
      conv_data <= 12'h000;
    end else if (conv_start) begin
      cnt <= slow ? 8 : 2;
      res <= {conv_temp, conv_diff, 5'h00, conv_channel};
    end else if (cnt == 1) begin
      cnt       <= 0;
      conv_done <= 1'b1;
      conv_data <= res;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule : asq_conv_model

// ===== sim/asq_assertions.sv
`timescale 1ns/100ps
module asq_assertions (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus answers
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_arready,
  // converter and outputs
  input wire logic        conv_start,
  input wire logic        conv_done,
  input wire logic [4:0]  conv_channel,
  input wire logic        cmp_valid,
  input wire logic [3:0]  seq_irq,
  input wire logic [3:0]  dma_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_dma_reset: assert property ($rose(aresetn) |-> dma_req == 4'h0)
    else $error("dma request after reset");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  a_fields_hold: assert property (!conv_start |-> $stable(conv_channel))
    else $error("channel moved without a start");
  a_irq_cause: assert property (seq_irq != 4'h0 |-> $past(conv_done))
    else $error("interrupt without completed step");
  a_irq_single: assert property ($onehot0(seq_irq))
    else $error("two sequencers completed at once");
  a_cmp_cause: assert property (cmp_valid |-> $past(conv_done) && seq_irq == 4'h0)
    else $error("comparator delivery without completion");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  c_start: cover property (conv_start);
  c_cmp: cover property (cmp_valid);
  c_irq: cover property (seq_irq[0]);
endmodule : asq_assertions
bind asq_top asq_assertions asq_assertions_inst (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_arready, .conv_start, .conv_done, .conv_channel,
  .cmp_valid, .seq_irq, .dma_req);

// ===== sim/testbench.sv
`timescale 1ns/100ps
module testbench;
  import asq_pkg::*;
  logic aclk = 0, aresetn = 0, slow = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, conv_start, conv_diff;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [3:0] trig_in = 0, seq_irq, dma_req;
  logic [3:0] s_axi_wstrb = 4'hF; // full-word writes only
  logic [4:0] conv_channel;
  logic conv_temp, conv_done, cmp_valid;
  logic [2:0] cmp_sel;
  asq_sample_t conv_data, cmp_data;
  logic [14:0] cmp_last;
  logic [4:0] chq[$];
  int num_errors = 0, checks = 0, irq_n = 0, cmp_n = 0;
  logic [11:0] exp_s[3] = '{12'h003, 12'h401, 12'h800};
  asq_top asq_top_inst (.*);
  asq_conv_model asq_conv_model_inst (.*);
  // clock
  initial forever #25 aclk = ~aclk;
  // watchdog
  initial begin
    #(50 * 20000);
    num_errors++;
    end_sim();
  end
  // event monitor
  always @(posedge aclk) begin
    if (seq_irq[0]) irq_n++;
    if (cmp_valid) begin
      cmp_n++;
      cmp_last = {cmp_sel, cmp_data};
    end
    if (conv_start) chq.push_back(conv_channel);
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // bus write, answer accepted one cycle after it appears
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // wait until the fill level of sequencer i reaches n
  task automatic poll(input int i, input logic [3:0] n);
    for (int k = 0; k < 80; k++) begin
      rd(12'h010);
      if (d[4*i+:4] === n) break;
    end
    chk(d[4*i+:4], n);
  endtask : poll
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h00C); chk(d, 32'hE4);
    rd(12'h000); chk(d, 32'h0);
    wr(12'h014, 32'h1); chk(r, 2'h2);
    wr(12'h0E4, 32'h1); chk(r, 2'h2);
    wr(12'h0B0, 32'h1); chk(r, 2'h2);
    $display("test registers done");
    // configured while disabled, no differential with temperature
    wr(12'h080, 32'h003); wr(12'h084, 32'h0A1); wr(12'h088, 32'h140);
    wr(12'h000, 32'h11);
    wr(12'h004, 32'h4);
    wr(12'h004, 32'h1);
    poll(0, 4'h3);
    chk(d[11:8], 4'h0);
    chk(dma_req, 4'h1);
    chk(irq_n, 1);
    foreach (exp_s[k]) begin
      rd(12'h020); chk(d, {20'h0, exp_s[k]});
    end
    chk(dma_req, 4'h0);
    $display("test sequence done");
    slow <= 1'b1;
    wr(12'h004, 32'h1);
    poll(0, 4'h1);
    rd(12'h020); chk(d, 32'h003);
    poll(0, 4'h2);
    slow <= 1'b0;
    wr(12'h004, 32'h1);
    poll(0, 4'h5);
    rd(12'h008); chk(d, 32'h01);
    wr(12'h008, 32'h01);
    rd(12'h008); chk(d, 32'h00);
    repeat (5) rd(12'h020);
    rd(12'h020); chk(d, 32'h0);
    chk(r, 2'h0);
    rd(12'h008); chk(d, 32'h10);
    wr(12'h008, 32'h10);
    rd(12'h008); chk(d, 32'h00);
    $display("test flags done");
    wr(12'h000, 32'h0);
    wr(12'h0E0, 32'h1702);
    wr(12'h000, 32'h08);
    wr(12'h004, 32'h8);
    for (int k = 0; k < 40 && cmp_n == 0; k++) @(posedge aclk);
    chk(cmp_n, 1); chk(cmp_last, {3'h5, 12'h002});
    rd(12'h010); chk(d[15:12], 4'h0);
    chk(dma_req, 4'h0);
    $display("test comparator done");
    wr(12'h000, 32'h0);
    wr(12'h0A0, 32'h107);
    wr(12'h00C, 32'hE1);
    wr(12'h000, 32'h03);
    chq.delete();
    wr(12'h004, 32'h3);
    poll(1, 4'h1);
    poll(0, 4'h3);
    chk(chq[0], 5'h07);
    rd(12'h024); chk(d, 32'h007);
    // pin trigger through the synchroniser, fifo empty so no overflow
    trig_in <= 4'h2;
    poll(1, 4'h1);
    trig_in <= 4'h0;
    rd(12'h008); chk(d, 32'h00);
    $display("test priority done");
    end_sim();
  end
endmodule : testbench
